/* verilog/frc_pkg.sv */
package frc_pkg;
	localparam logic [4:0] FRC_OP_READ = 5'h06;
	localparam logic [4:0] FRC_OP_DELETED = 5'h0C;
	localparam logic [4:0] FRC_OP_TRACK = 5'h02;
	localparam int FRC_MT_BIT = 7;
	localparam int FRC_DD_BIT = 6;
	localparam int FRC_SK_BIT = 5;
	localparam int FRC_HEAD_BIT = 2;
	localparam logic [2:0] FRC_PARAM_COUNT = 3'h7;
	localparam logic [2:0] FRC_RESULT_COUNT = 3'h7;
	localparam int FRC_FIFO_DEPTH = 16;
	localparam logic [7:0] FRC_ST0_RESET = 8'h00;

	typedef enum logic [1:0] {
		FRC_KIND_READ = 2'b00,
		FRC_KIND_DELETED = 2'b01,
		FRC_KIND_TRACK = 2'b10,
		FRC_KIND_NONE = 2'b11
	} frc_kind_t;

	typedef struct packed {
		logic multi_track_flag;
		logic double_density_select;
		logic skip_deleted_flag;
		logic head_select;
		logic drive_select_high;
		logic drive_select_low;
	} frc_flags_t;

	typedef struct packed {
		logic [7:0] cylinder;
		logic [7:0] head;
		logic [7:0] record;
		logic [7:0] size_code;
	} frc_id_t;

	typedef struct packed {
		logic [7:0] status_byte_zero;
		logic [7:0] status_byte_one;
		logic [7:0] status_byte_two;
	} frc_status_t;
endpackage : frc_pkg

/* verilog/frc_fifo.sv */
`timescale 1ns/1ns
module frc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clocking
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clk_en,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// flush
	input wire logic flush
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rd_reg];

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		mem_next = mem_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (flush) begin
			wr_next = '0;
			rd_next = '0;
			cnt_next = '0;
		end else begin
			if (push) begin
				mem_next[wr_reg] = in_data;
				wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
			end
			if (pop)
				rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
			cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else if (clk_en) begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage needs no reset; count guards reads
	always_ff @(posedge mclk) begin
		if (clk_en)
			mem_reg <= mem_next;
	end
endmodule : frc_fifo

/* verilog/frc_core.sv */
//
// Contract
// - deleted read byte 0: multi-track b7, density b6, skip b5, low 01100
// - byte 1: bits 7..3 zero, head b2, drive select b1..b0
// - execution passes sector data from the drive to the system
// - result starts with status bytes zero, one, two
// - then cylinder, head, record, size code at end position
// - track read starts at index hole, reads sectors to final sector
// - track read byte 0: b7 zero, no skip, density b6, low 00010
`timescale 1ns/1ns
module frc_core import frc_pkg::*; #(
	parameter int DATA_W = 8,
	parameter int FIFO_DEPTH = FRC_FIFO_DEPTH
) (
	// clocking
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clk_en,
	// host data register
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_wdata,
	input wire logic res_rd,
	output logic [7:0] res_rdata,
	output logic res_valid,
	output logic cmd_ready,
	output logic cmd_error,
	// drive side
	input wire logic index_hole,
	input wire logic disk_valid,
	input wire logic [DATA_W-1:0] disk_data,
	input wire logic sector_end,
	input wire logic [7:0] sector_record,
	input wire logic sector_deleted,
	output logic disk_ready,
	output logic disk_read_en,
	// system side
	output logic sys_valid,
	input wire logic sys_ready,
	output logic [DATA_W-1:0] sys_data,
	// decoded command for drive control
	output frc_flags_t flags_out,
	output logic [1:0] kind_out,
	output logic busy
);
	typedef enum logic [2:0] {
		FRC_S_IDLE = 3'b000,
		FRC_S_SELECT = 3'b001,
		FRC_S_PARAM = 3'b010,
		FRC_S_INDEX = 3'b011,
		FRC_S_EXEC = 3'b100,
		FRC_S_RESULT = 3'b101
	} frc_state_t;

	frc_state_t state_reg, state_next;
	frc_kind_t kind_reg, kind_next;
	frc_flags_t flags_reg, flags_next;
	frc_id_t id_reg, id_next;
	logic [7:0] eot_reg, eot_next;
	logic [7:0] gap_reg, gap_next;
	logic [7:0] dtl_reg, dtl_next;
	logic [2:0] idx_reg, idx_next;
	logic [7:0] res_rdata_reg, res_rdata_next;
	logic res_valid_reg, res_valid_next;
	logic cmd_error_reg, cmd_error_next;
	logic skip_reg, skip_next;
	logic rd_en_reg, rd_en_next;
	logic cmd_ready_reg, cmd_ready_next;
	logic busy_reg, busy_next;
	frc_status_t st_reg, st_next;
	logic fifo_in_valid, fifo_in_ready, fifo_flush;

	// decode of first command byte, shared by accept, error and kind capture
	function automatic frc_kind_t frc_decode(input logic [7:0] b);
		if (b[4:0] == FRC_OP_READ)
			frc_decode = FRC_KIND_READ;
		else if (b[4:0] == FRC_OP_DELETED)
			frc_decode = FRC_KIND_DELETED;
		else if (b[4:0] == FRC_OP_TRACK && !b[FRC_MT_BIT] && !b[FRC_SK_BIT])
			frc_decode = FRC_KIND_TRACK;
		else
			frc_decode = FRC_KIND_NONE;
	endfunction : frc_decode

	// result byte by position
	function automatic logic [7:0] frc_result(input logic [2:0] i, input frc_status_t s,
			input frc_id_t id);
		case (i)
			3'h0: frc_result = s.status_byte_zero;
			3'h1: frc_result = s.status_byte_one;
			3'h2: frc_result = s.status_byte_two;
			3'h3: frc_result = id.cylinder;
			3'h4: frc_result = id.head;
			3'h5: frc_result = id.record;
			3'h6: frc_result = id.size_code;
			default: frc_result = 8'h00;
		endcase
	endfunction : frc_result

	// deleted sectors are dropped only when skip is set on a data read
	logic drop_sector;
	assign drop_sector = skip_reg && sector_deleted && (kind_reg != FRC_KIND_TRACK);
	assign fifo_in_valid = (state_reg == FRC_S_EXEC) && disk_valid && !drop_sector;
	// no flush at idle: bytes still queued are owed to the system side
	assign fifo_flush = 1'b0;

	frc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rstn(rstn),
		.clk_en(clk_en),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(disk_data),
		.out_valid(sys_valid),
		.out_ready(sys_ready),
		.out_data(sys_data),
		.flush(fifo_flush)
	);

	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		flags_next = flags_reg;
		id_next = id_reg;
		eot_next = eot_reg;
		gap_next = gap_reg;
		dtl_next = dtl_reg;
		idx_next = idx_reg;
		res_rdata_next = res_rdata_reg;
		res_valid_next = res_valid_reg;
		cmd_error_next = cmd_error_reg;
		skip_next = skip_reg;
		rd_en_next = rd_en_reg;
		st_next = st_reg;
		case (state_reg)
			FRC_S_IDLE: begin
				if (cmd_wr) begin
					kind_next = frc_decode(cmd_wdata);
					cmd_error_next = (frc_decode(cmd_wdata) == FRC_KIND_NONE);
					flags_next.multi_track_flag = cmd_wdata[FRC_MT_BIT];
					flags_next.double_density_select = cmd_wdata[FRC_DD_BIT];
					flags_next.skip_deleted_flag = cmd_wdata[FRC_SK_BIT];
					skip_next = cmd_wdata[FRC_SK_BIT];
					if (frc_decode(cmd_wdata) != FRC_KIND_NONE)
						state_next = FRC_S_SELECT;
				end
			end
			FRC_S_SELECT: begin
				if (cmd_wr) begin
					flags_next.head_select = cmd_wdata[FRC_HEAD_BIT];
					flags_next.drive_select_high = cmd_wdata[1];
					flags_next.drive_select_low = cmd_wdata[0];
					idx_next = 3'h0;
					state_next = FRC_S_PARAM;
				end
			end
			FRC_S_PARAM: begin
				if (cmd_wr) begin
					case (idx_reg)
						3'h0: id_next.cylinder = cmd_wdata;
						3'h1: id_next.head = cmd_wdata;
						3'h2: id_next.record = cmd_wdata;
						3'h3: id_next.size_code = cmd_wdata;
						3'h4: eot_next = cmd_wdata;
						3'h5: gap_next = cmd_wdata;
						3'h6: dtl_next = cmd_wdata;
						default: ;
					endcase
					idx_next = idx_reg + 3'h1;
					if (idx_reg == FRC_PARAM_COUNT - 3'h1) begin
						st_next = '0;
						st_next.status_byte_zero = {5'h00, flags_reg.head_select,
							flags_reg.drive_select_high, flags_reg.drive_select_low};
						if (kind_reg == FRC_KIND_TRACK) begin
							state_next = FRC_S_INDEX;
						end else begin
							state_next = FRC_S_EXEC;
							rd_en_next = 1'b1;
						end
					end
				end
			end
			FRC_S_INDEX: begin
				if (index_hole) begin
					state_next = FRC_S_EXEC;
					rd_en_next = 1'b1;
					id_next.record = 8'h01;
				end
			end
			FRC_S_EXEC: begin
				// end of sector: stop at final sector, else next record
				if (sector_end) begin
					id_next.record = sector_record;
					if (sector_record == eot_reg) begin
						state_next = FRC_S_RESULT;
						rd_en_next = 1'b0;
						idx_next = 3'h0;
						res_valid_next = 1'b1;
						res_rdata_next = frc_result(3'h0, st_reg, id_reg);
						if (kind_reg == FRC_KIND_DELETED)
							st_next.status_byte_two = 8'h00;
					end else begin
						id_next.record = sector_record + 8'h01;
					end
				end
			end
			FRC_S_RESULT: begin
				if (res_rd) begin
					idx_next = idx_reg + 3'h1;
					if (idx_reg == FRC_RESULT_COUNT - 3'h1) begin
						state_next = FRC_S_IDLE;
						res_valid_next = 1'b0;
						res_rdata_next = 8'h00;
					end else begin
						res_rdata_next = frc_result(idx_reg + 3'h1, st_reg, id_reg);
					end
				end
			end
			default: state_next = FRC_S_IDLE;
		endcase
		// registered so the port comes straight from a flip-flop
		cmd_ready_next = (state_next == FRC_S_IDLE) || (state_next == FRC_S_SELECT)
			|| (state_next == FRC_S_PARAM);
		busy_next = (state_next != FRC_S_IDLE);
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_reg <= FRC_S_IDLE;
			kind_reg <= FRC_KIND_NONE;
			flags_reg <= '0;
			id_reg <= '0;
			eot_reg <= 8'h00;
			gap_reg <= 8'h00;
			dtl_reg <= 8'h00;
			idx_reg <= 3'h0;
			res_rdata_reg <= 8'h00;
			res_valid_reg <= 1'b0;
			cmd_error_reg <= 1'b0;
			skip_reg <= 1'b0;
			rd_en_reg <= 1'b0;
			cmd_ready_reg <= 1'b1;
			busy_reg <= 1'b0;
			st_reg <= {FRC_ST0_RESET, 8'h00, 8'h00};
		end else if (clk_en) begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			flags_reg <= flags_next;
			id_reg <= id_next;
			eot_reg <= eot_next;
			gap_reg <= gap_next;
			dtl_reg <= dtl_next;
			idx_reg <= idx_next;
			res_rdata_reg <= res_rdata_next;
			res_valid_reg <= res_valid_next;
			cmd_error_reg <= cmd_error_next;
			skip_reg <= skip_next;
			rd_en_reg <= rd_en_next;
			cmd_ready_reg <= cmd_ready_next;
			busy_reg <= busy_next;
			st_reg <= st_next;
		end
	end

	// registered status outputs; disk_ready follows fifo room directly, but only in execution
	assign res_rdata = res_rdata_reg;
	assign res_valid = res_valid_reg;
	assign cmd_error = cmd_error_reg;
	assign disk_read_en = rd_en_reg;
	assign flags_out = flags_reg;
	assign kind_out = kind_reg;
	// new command bytes only in idle, select or parameter phases
	assign cmd_ready = cmd_ready_reg;
	assign busy = busy_reg;
	assign disk_ready = fifo_in_ready && (state_reg == FRC_S_EXEC);
endmodule : frc_core

/* sim/frc_core_sva.sv */
`timescale 1ns/1ns
module frc_core_sva import frc_pkg::*; (
	// clocking
	input wire logic mclk,
	input wire logic rstn,
	// host side
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_wdata,
	input wire logic res_rd,
	input wire logic [7:0] res_rdata,
	input wire logic res_valid,
	input wire logic cmd_ready,
	input wire logic cmd_error,
	// drive side
	input wire logic sector_end,
	input wire logic index_hole,
	input wire logic [7:0] sector_record,
	input wire logic disk_read_en,
	// decode
	input wire frc_flags_t flags_out,
	input wire logic [1:0] kind_out,
	input wire logic busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic take;
	logic known;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sel_reg, sel_next, fin_reg, fin_next;
	assign take = cmd_wr && cmd_ready;
	assign known = cmd_wdata[4:0] inside {FRC_OP_READ, FRC_OP_DELETED, FRC_OP_TRACK};
	// byte position in the command, so checks know which byte is which
	always_comb begin
		cnt_next = cnt_reg;
		sel_next = sel_reg;
		fin_next = fin_reg;
		if (take) begin
			cnt_next = (cnt_reg == 4'h8 || (cnt_reg == 4'h0 && !known)) ? 4'h0 : cnt_reg + 4'h1;
			if (cnt_reg == 4'h1) sel_next = cmd_wdata;
			if (cnt_reg == 4'h6) fin_next = cmd_wdata;
		end
	end
	always_ff @(posedge mclk) begin
		cnt_reg <= rstn ? cnt_next : 4'h0;
		sel_reg <= sel_next;
		fin_reg <= fin_next;
	end
	reset_state_a: assert property (disable iff (1'b0) !rstn |=> kind_out == 2'h3
		&& cmd_ready && !res_valid && !busy) else $error("bad reset state");
	exec_after_params_a: assert property ($rose(disk_read_en) |->
		($past(take) && $past(cnt_reg) == 4'h8)
		|| (kind_out == FRC_KIND_TRACK && $past(index_hole)))
		else $error("execution before last parameter");
	res_first_a: assert property (sector_end && disk_read_en && sector_record == fin_reg
		|=> res_valid && res_rdata == {5'h00, sel_reg[2:0]}) else $error("first result wrong");
	res_hold_a: assert property (res_valid && !res_rd |=> res_valid && $stable(res_rdata))
		else $error("result byte not held");
	result_closed_a: assert property (res_valid |-> !cmd_ready)
		else $error("command open");
	bad_op_a: assert property (take && cnt_reg == 4'h0 && !known |=> cmd_error && !busy)
		else $error("unknown op accepted");
	read_kind_a: assert property (take && cnt_reg == 4'h0 && cmd_wdata[4:0] == FRC_OP_READ
		|=> kind_out == FRC_KIND_READ) else $error("read op not decoded");
	deleted_kind_a: assert property (take && cnt_reg == 4'h0
		&& cmd_wdata[4:0] == FRC_OP_DELETED |=> kind_out == FRC_KIND_DELETED)
		else $error("deleted op not decoded");
	track_kind_a: assert property (take && cnt_reg == 4'h0 && cmd_wdata[4:0] == FRC_OP_TRACK
		|=> kind_out == FRC_KIND_TRACK) else $error("track op not decoded");
	select_flags_a: assert property (take && cnt_reg == 4'h1 |=>
		flags_out[2:0] == $past(cmd_wdata[2:0])) else $error("select flags wrong");
	cover property ($rose(res_valid));
	cover property (take && cnt_reg == 4'h0 && !known);
	cover property (sector_end && kind_out == FRC_KIND_TRACK);
endmodule : frc_core_sva
bind frc_core frc_core_sva frc_core_sva_i (.mclk, .rstn, .cmd_wr, .cmd_wdata, .res_rd, .res_rdata,
	.res_valid, .cmd_ready, .cmd_error, .sector_end, .index_hole, .sector_record, .disk_read_en,
	.flags_out,
	.kind_out, .busy);

/* sim/frc_drive_model.sv */
`timescale 1ns/1ns
module frc_drive_model (
	// clocking
	input wire logic mclk,
	// control
	input wire logic disk_read_en,
	input wire logic disk_ready,
	input wire logic [7:0] first_rec,
	input wire logic [7:0] last_rec,
	// drive outputs
	output logic index_hole,
	output logic disk_valid,
	output logic [7:0] disk_data,
	output logic sector_end,
	output logic [7:0] sector_record,
	output logic sector_deleted
);
	logic [7:0] rec;
	initial begin
		{index_hole, disk_valid, sector_end, sector_deleted} = 4'h0;
		disk_data = 8'h00;
		sector_record = 8'h00;
		forever begin
			@(posedge mclk);
			// the hole passes every other cycle while the drive is not reading
			if (disk_read_en !== 1'b1) begin
				index_hole <= !index_hole;
			end else begin
				index_hole <= 1'b0;
				for (rec = first_rec; rec <= last_rec; rec++) begin
					for (int i = 0; i < 16; i++) begin
						disk_valid <= 1'b1;
						disk_data <= {rec[3:0], 4'(i)};
						do @(posedge mclk); while (disk_ready !== 1'b1);
					end
					disk_valid <= 1'b0;
					// stale data flipped so a late sample cannot pass
					disk_data <= ~disk_data;
					sector_end <= 1'b1;
					sector_record <= rec;
					@(posedge mclk);
					sector_end <= 1'b0;
				end
				while (disk_read_en === 1'b1) @(posedge mclk);
			end
		end
	end
endmodule : frc_drive_model

/* sim/floppy_read_command_phases_bench.sv */
`timescale 1ns/1ns
module floppy_read_command_phases_bench import frc_pkg::*; ;
	logic mclk = 0, rstn = 0, cmd_wr = 0, res_rd = 0, sys_ready = 0, stall = 1;
	logic [7:0] cmd_wdata = 8'h00, first_rec = 8'h01, last_rec = 8'h01;
	logic [31:0] lfsr = 32'h6AF4;
	logic [7:0] res_rdata, disk_data, sector_record, sys_data;
	logic res_valid, cmd_ready, cmd_error, index_hole, disk_valid, sector_end, sector_deleted;
	logic disk_ready, disk_read_en, sys_valid, busy;
	logic [1:0] kind_out;
	frc_flags_t flags_out;
	int n_errors = 0, n_compared = 0, rx = 0, acc = 0, rx_base = 0;
	frc_core frc_core_i (.mclk, .rstn, .clk_en(1'b1), .cmd_wr, .cmd_wdata, .res_rd, .res_rdata,
		.res_valid, .cmd_ready, .cmd_error, .index_hole, .disk_valid, .disk_data, .sector_end,
		.sector_record, .sector_deleted, .disk_ready, .disk_read_en, .sys_valid, .sys_ready,
		.sys_data, .flags_out, .kind_out, .busy);
	frc_drive_model frc_drive_model_i (.mclk, .disk_read_en, .disk_ready, .first_rec, .last_rec,
		.index_hole, .disk_valid, .disk_data, .sector_end, .sector_record, .sector_deleted);
	initial forever #5 mclk = ~mclk;
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next
	function automatic logic [7:0] exp_byte(input int i);
		logic [7:0] r;
		r = first_rec + 8'(i / 16);
		return {r[3:0], 4'(i)};
	endfunction : exp_byte
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task automatic end_sim;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// strobe stays up across bytes; caller lowers it after the last one
	task automatic wr(input logic [7:0] b);
		int k;
		k = 0;
		cmd_wr <= 1'b1;
		cmd_wdata <= b;
		do begin @(posedge mclk); k++; end while (cmd_ready !== 1'b1 && k < 50);
	endtask : wr
	task automatic rd(input logic [7:0] e);
		int k;
		k = 0;
		while (res_valid !== 1'b1 && k < 2000) begin @(posedge mclk); k++; end
		chk("result", e, res_rdata);
		res_rd <= 1'b1;
		@(posedge mclk);
		res_rd <= 1'b0;
		@(posedge mclk);
	endtask : rd
	task automatic op(input logic [1:0] kind);
		logic [7:0] b0, sel, fin, c, h, n;
		logic multi, dens, skip;
		int acc0;
		multi = lfsr[3] && kind != 2'h2;
		dens = lfsr[4];
		skip = lfsr[5] && kind != 2'h2;
		sel = {5'h00, lfsr[8:6]};
		{c, h, n} = {lfsr[15:8], lfsr[23:16], 5'h00, lfsr[26:24]};
		first_rec = kind == 2'h2 ? 8'h01 : {6'h00, lfsr[28:27]} + 8'h01;
		fin = first_rec + 8'h01 + {7'h00, lfsr[29]};
		last_rec = fin;
		b0 = kind == 2'h0 ? {multi, dens, skip, FRC_OP_READ} : kind == 2'h1 ?
			{multi, dens, skip, FRC_OP_DELETED} : {1'b0, dens, 1'b0, FRC_OP_TRACK};
		stall <= 1'b1;
		acc0 = acc;
		rx_base = rx;
		wr(b0);
		wr(sel);
		chk("kind", {6'h00, kind}, {6'h00, kind_out});
		wr(c);
		chk("flags", {2'h0, multi, dens, skip, sel[2:0]}, {2'h0, flags_out});
		wr(h);
		wr(first_rec);
		wr(n);
		wr(fin);
		wr(8'h1B);
		wr(8'hFF);
		cmd_wr <= 1'b0;
		repeat (40) @(posedge mclk);
		chk("fill", 8'(FRC_FIFO_DEPTH), 8'(acc - acc0));
		stall <= 1'b0;
		rd({5'h00, sel[2:0]});
		rd(8'h00);
		rd(8'h00);
		rd(c);
		rd(h);
		rd(fin);
		rd(n);
		repeat (40) @(posedge mclk);
		chk("count", 8'((fin - first_rec + 8'h01) * 16), 8'(rx - rx_base));
	endtask : op
	always @(posedge mclk) begin
		lfsr <= lfsr_next(lfsr);
		if (stall && disk_valid && disk_ready === 1'b1) acc++;
		if (sys_valid === 1'b1 && sys_ready) begin
			chk("sys_data", exp_byte(rx - rx_base), sys_data);
			rx++;
		end
		sys_ready <= !stall && lfsr[0];
	end
	initial begin
		#200000;
		n_errors++;
		end_sim;
	end
	initial begin
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		wr(8'h1F);
		cmd_wr <= 1'b0;
		@(posedge mclk);
		chk("error", 8'h01, {7'h00, cmd_error});
		for (int k = 0; k < 6; k++) op(k < 3 ? 2'(k) : 2'(lfsr % 3));
		end_sim;
	end
endmodule : floppy_read_command_phases_bench
